//--- rtl/egress_sched_pkg.sv
package egress_sched_pkg;

  // ----------------------------------------------------------------
  // queue and tag geometry
  // ----------------------------------------------------------------
  localparam int NUM_QUEUES = 4;
  localparam int QIDX_W = 2;
  localparam int PRIO_W = 3;
  localparam int PRIO_MAX = 7;

  localparam logic [1:0] QUEUE_LOWEST = 2'h0;
  localparam logic [1:0] QUEUE_LOW_MID = 2'h1;
  localparam logic [1:0] QUEUE_HIGH_MID = 2'h2;
  localparam logic [1:0] QUEUE_HIGHEST = 2'h3;

  // ----------------------------------------------------------------
  // reset defaults
  // ----------------------------------------------------------------
  // tag p selects bits [2p+1:2p]: 7,6->3  5,4->2  3->1  2,1->0  0->1
  localparam logic [15:0] DEFAULT_PRIO_MAP = 16'hFA41;
  // queue q weight in nibble q: 1:2:4:8
  localparam int DEFAULT_WEIGHT_W = 4;
  localparam logic [15:0] DEFAULT_WEIGHTS = 16'h8421;
  localparam int DEFAULT_DEPTH = 8;
  localparam int DEFAULT_DATA_W = 32;
  localparam int DEFAULT_NUM_PORTS = 4;

endpackage : egress_sched_pkg

//--- rtl/egress_class_queues.sv
`timescale 1ns/10ps

module egress_class_queues #(
  parameter int DATA_W = egress_sched_pkg::DEFAULT_DATA_W,
  parameter int DEPTH = egress_sched_pkg::DEFAULT_DEPTH
) (
  input logic sys_clk,
  input logic rstnSync,
  input logic push,
  input logic [1:0] pushQ,
  input logic [DATA_W-1:0] pushData,
  input logic pop,
  input logic [1:0] popQ,
  output logic ready,
  output logic [3:0] nonEmpty,
  output logic [3:0][DATA_W-1:0] head
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two, at least 2");
    end
  end

  typedef struct packed {
    logic [3:0][DEPTH-1:0][DATA_W-1:0] mem;
    logic [3:0][AW-1:0] wrPtr;
    logic [3:0][AW-1:0] rdPtr;
    logic [3:0][CW-1:0] count;
    logic ready;
  } store_t;

  store_t st;
  store_t next_st;

  // ----------------------------------------------------------------
  // four independent descriptor rings
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[pushQ][st.wrPtr[pushQ]] = pushData;
      next_st.wrPtr[pushQ] = st.wrPtr[pushQ] + AW'(1);
    end
    if (pop) begin
      next_st.rdPtr[popQ] = st.rdPtr[popQ] + AW'(1);
    end
    next_st.ready = 1'b1;
    for (int q = 0; q < 4; q++) begin
      next_st.count[q] = st.count[q] + CW'(push && pushQ == 2'(q)) - CW'(pop && popQ == 2'(q));
      // ready is registered, so it must promise room for the push taken next cycle
      if (next_st.count[q] >= CW'(DEPTH)) begin
        next_st.ready = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ready = st.ready;

  genvar gq;
  generate
    for (gq = 0; gq < 4; gq++) begin : g_head
      assign nonEmpty[gq] = st.count[gq] != '0;
      assign head[gq] = st.mem[gq][st.rdPtr[gq]];
    end
  endgenerate

endmodule : egress_class_queues

//--- rtl/egress_priority_queue_scheduler.sv
`timescale 1ns/10ps

// Function
// - four egress queues per port, queue 3 highest priority, queue 0 lowest.
// - priority tag is three bits, 0 lowest traffic up to 7 highest.
// - default map sends tags 1 and 2 to queue 0.
// - default map sends tags 0 and 3 to queue 1.
// - default map sends tags 4 and 5 to queue 2.
// - default map sends tags 6 and 7 to queue 3.
// - strict queues with frames always go before any lower queue.
// - several strict queues drain in descending priority order.
// - per round each weighted queue sends as many frames as its weight.
// - equal weights of 1 give plain round robin among weighted queues.
// - zero-weight queue gets no service; others keep weighted round robin.
// - default weights for queues 0 to 3 are 1:2:4:8.
// - one global map and schedule setting applies to every port.
// - each port owns its own independent set of egress queues.
// - untagged frame takes its port default priority before queue mapping.
module egress_priority_queue_scheduler #(
  parameter int NUM_PORTS = egress_sched_pkg::DEFAULT_NUM_PORTS,
  parameter int DATA_W = egress_sched_pkg::DEFAULT_DATA_W,
  parameter int DEPTH = egress_sched_pkg::DEFAULT_DEPTH,
  parameter int WEIGHT_W = egress_sched_pkg::DEFAULT_WEIGHT_W
) (
  input logic sys_clk,
  input logic rstn,
  input logic [3:0] strictMask,
  input logic mapOverride,
  input logic [7:0][1:0] prioMap,
  input logic weightOverride,
  input logic [3:0][WEIGHT_W-1:0] weights,
  input logic [NUM_PORTS-1:0][2:0] defaultPrio,
  input logic [NUM_PORTS-1:0] inValid,
  output logic [NUM_PORTS-1:0] inReady,
  input logic [NUM_PORTS-1:0] inTagPresent,
  input logic [NUM_PORTS-1:0][2:0] inPrio,
  input logic [NUM_PORTS-1:0][DATA_W-1:0] inData,
  output logic [NUM_PORTS-1:0] txValid,
  input logic [NUM_PORTS-1:0] txReady,
  output logic [NUM_PORTS-1:0][DATA_W-1:0] txData,
  output logic [NUM_PORTS-1:0][1:0] txQueue
);

  initial begin
    if (NUM_PORTS < 1 || DATA_W < 1 || WEIGHT_W < 4 || WEIGHT_W > 16) begin
      $error("unsupported NUM_PORTS, DATA_W or WEIGHT_W");
    end
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstnSync;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstnSync = rstSync[1];

  // ----------------------------------------------------------------
  // global configuration, shared by all ports
  // ----------------------------------------------------------------
  logic [7:0][1:0] mapEff;
  logic [3:0][WEIGHT_W-1:0] weightEff;
  logic [3:0][WEIGHT_W-1:0] weightDefault;

  always_comb begin
    mapEff = mapOverride ? prioMap : egress_sched_pkg::DEFAULT_PRIO_MAP;
    for (int q = 0; q < 4; q++) begin
      weightDefault[q] = WEIGHT_W'(egress_sched_pkg::DEFAULT_WEIGHTS[q*4 +: 4]);
    end
    weightEff = weightOverride ? weights : weightDefault;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PORTS-1:0] txValid;
    logic [NUM_PORTS-1:0][DATA_W-1:0] txData;
    logic [NUM_PORTS-1:0][1:0] txQueue;
    logic [NUM_PORTS-1:0][1:0] cur;
    logic [NUM_PORTS-1:0][3:0][WEIGHT_W-1:0] credit;
  } sched_t;

  sched_t st;
  sched_t next_st;

  logic [NUM_PORTS-1:0][2:0] effPrio;
  logic [NUM_PORTS-1:0][1:0] pushQ;
  logic [NUM_PORTS-1:0] push;
  logic [NUM_PORTS-1:0] popEn;
  logic [NUM_PORTS-1:0][1:0] popQ;
  logic [NUM_PORTS-1:0] reload;
  logic [NUM_PORTS-1:0][3:0] nonEmpty;
  logic [NUM_PORTS-1:0][3:0][DATA_W-1:0] head;
  logic [NUM_PORTS-1:0] qReady;
  logic [NUM_PORTS-1:0][WEIGHT_W-1:0] popCredit;

  // ----------------------------------------------------------------
  // per-port classification and queue stores
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign effPrio[gp] = inTagPresent[gp] ? inPrio[gp] : defaultPrio[gp];
      assign pushQ[gp] = mapEff[effPrio[gp]];
      assign push[gp] = inValid[gp] && qReady[gp];
      assign popCredit[gp] = st.credit[gp][popQ[gp]];

      egress_class_queues #(
        .DATA_W(DATA_W),
        .DEPTH(DEPTH)
      ) u_queues (
        .sys_clk(sys_clk),
        .rstnSync(rstnSync),
        .push(push[gp]),
        .pushQ(pushQ[gp]),
        .pushData(inData[gp]),
        .pop(popEn[gp]),
        .popQ(popQ[gp]),
        .ready(qReady[gp]),
        .nonEmpty(nonEmpty[gp]),
        .head(head[gp])
      );

      AST_MAP_LOWEST: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        push[gp] && !mapOverride && (effPrio[gp] == 3'h1 || effPrio[gp] == 3'h2) |-> pushQ[gp] == 2'h0)
        else $error("tag 1 or 2 not sent to lowest queue");
      AST_MAP_LOW_MID: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        push[gp] && !mapOverride && (effPrio[gp] == 3'h0 || effPrio[gp] == 3'h3) |-> pushQ[gp] == 2'h1)
        else $error("tag 0 or 3 not sent to queue 1");
      AST_MAP_HIGH_MID: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        push[gp] && !mapOverride && (effPrio[gp] == 3'h4 || effPrio[gp] == 3'h5) |-> pushQ[gp] == 2'h2)
        else $error("tag 4 or 5 not sent to queue 2");
      AST_MAP_HIGHEST: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        push[gp] && !mapOverride && effPrio[gp][2:1] == 2'h3 |-> pushQ[gp] == 2'h3)
        else $error("tag 6 or 7 not sent to highest queue");
      AST_UNTAGGED_DEFAULT: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        push[gp] && !inTagPresent[gp] |-> pushQ[gp] == mapEff[defaultPrio[gp]])
        else $error("untagged frame ignored port default priority");
      AST_STRICT_FIRST: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && !strictMask[popQ[gp]] |-> (strictMask & nonEmpty[gp]) == 4'h0)
        else $error("weighted queue served while a strict queue held frames");
      AST_STRICT_ORDER: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && strictMask[popQ[gp]] |-> 4'((strictMask & nonEmpty[gp]) >> popQ[gp]) == 4'h1)
        else $error("strict queue served below a higher waiting strict queue");
      AST_TX_QUEUE: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] |=> txValid[gp] && txQueue[gp] == $past(popQ[gp]))
        else $error("transmitted frame does not carry its queue number");
      AST_ZERO_WEIGHT: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && !strictMask[popQ[gp]] |-> weightEff[popQ[gp]] != '0)
        else $error("zero-weight queue was served");
      AST_CREDIT_DROP: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && !strictMask[popQ[gp]] && !weightOverride
        |=> st.credit[gp][$past(popQ[gp])] == $past(popCredit[gp]) - WEIGHT_W'(1))
        else $error("credit not reduced by one per weighted frame");
      AST_ROUND_LOAD: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        reload[gp] |=> st.credit[gp] == $past(weightEff))
        else $error("round did not load credits from weights");
      AST_DEFAULT_WEIGHTS: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        reload[gp] && !weightOverride |=> st.credit[gp] == egress_sched_pkg::DEFAULT_WEIGHTS[4*WEIGHT_W-1:0])
        else $error("default weights are not 1:2:4:8");
      AST_EQUAL_TURN: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && !strictMask[popQ[gp]] && popCredit[gp] == WEIGHT_W'(1) && weightOverride
        && weights == {4{weights[0]}} && weights[0] == WEIGHT_W'(1) ##1 popEn[gp] && !strictMask[popQ[gp]]
        |-> popQ[gp] != $past(popQ[gp]) || nonEmpty[gp] == (4'h1 << popQ[gp]))
        else $error("equal weights did not rotate among queues");

      // ----------------------------------------------------------------
      // scheduling and egress monitors
      // ----------------------------------------------------------------
      AST_STRICT_SERVE: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        (!txValid[gp] || txReady[gp]) && (strictMask & nonEmpty[gp]) != 4'h0
        |-> popEn[gp] && strictMask[popQ[gp]])
        else $error("waiting strict queue not served at a free slot");
      AST_WRR_ROTATE: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && !strictMask[popQ[gp]] && popCredit[gp] == WEIGHT_W'(1)
        |=> st.cur[gp] == 2'($past(popQ[gp]) + 2'h1))
        else $error("spent queue did not hand its turn to the next queue");
      AST_CREDIT_STAY: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        !reload[gp] && !(popEn[gp] && !strictMask[popQ[gp]])
        |=> st.credit[gp] == $past(st.credit[gp]))
        else $error("credit changed without a frame or a new round");
      AST_CREDIT_LEFT: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] && !strictMask[popQ[gp]] |-> popCredit[gp] != '0)
        else $error("weighted queue sent more frames than its weight");
      AST_TX_HOLD: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        txValid[gp] && !txReady[gp] |=> txValid[gp] && $stable(txData[gp]) && $stable(txQueue[gp]))
        else $error("frame or queue number changed before the mac took it");
      AST_OWN_QUEUE: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        popEn[gp] |-> nonEmpty[gp][popQ[gp]])
        else $error("frame taken from an empty queue of this port");
      AST_MAP_GLOBAL: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        push[gp] && mapOverride |-> pushQ[gp] == prioMap[effPrio[gp]])
        else $error("shared tag map not applied to this port");
      AST_EMPTY_NO_TX: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        (!txValid[gp] || txReady[gp]) && nonEmpty[gp] == 4'h0 |=> !txValid[gp])
        else $error("frame sent while every queue of this port was empty");
      AST_ROUND_END: assert property (@(posedge sys_clk) disable iff (!rstnSync)
        reload[gp] |-> (~strictMask & nonEmpty[gp]
        & {st.credit[gp][3] != '0, st.credit[gp][2] != '0, st.credit[gp][1] != '0, st.credit[gp][0] != '0}
        & {weightEff[3] != '0, weightEff[2] != '0, weightEff[1] != '0, weightEff[0] != '0}) == 4'h0)
        else $error("new round started while a weighted queue still held credit");
    end
  endgenerate

  // ----------------------------------------------------------------
  // scheduler: strict first, then weighted round robin on credits
  // ----------------------------------------------------------------
  always_comb begin
    logic strictFound;
    logic wrrFound;
    logic [1:0] strictPick;
    logic [1:0] wrrPick;
    logic [3:0] eligible;
    logic [1:0] cand;
    next_st = st;
    popEn = '0;
    popQ = '0;
    reload = '0;
    strictFound = 1'b0;
    wrrFound = 1'b0;
    strictPick = 2'h0;
    wrrPick = 2'h0;
    eligible = 4'h0;
    cand = 2'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      strictFound = 1'b0;
      strictPick = 2'h0;
      for (int q = 0; q < 4; q++) begin
        if (strictMask[q] && nonEmpty[p][q]) begin
          strictFound = 1'b1;
          strictPick = 2'(q);
        end
        eligible[q] = !strictMask[q] && nonEmpty[p][q] && st.credit[p][q] != '0
          && weightEff[q] != '0;
      end
      wrrFound = 1'b0;
      wrrPick = st.cur[p];
      if (eligible[st.cur[p]]) begin
        wrrFound = 1'b1;
      end else begin
        for (int k = 3; k >= 1; k--) begin
          cand = 2'(st.cur[p] + 2'(k));
          if (eligible[cand]) begin
            wrrFound = 1'b1;
            wrrPick = cand;
          end
        end
      end
      if (!st.txValid[p] || txReady[p]) begin
        next_st.txValid[p] = 1'b0;
        if (strictFound) begin
          popEn[p] = 1'b1;
          popQ[p] = strictPick;
        end else if (wrrFound) begin
          popEn[p] = 1'b1;
          popQ[p] = wrrPick;
          next_st.cur[p] = wrrPick;
          next_st.credit[p][wrrPick] = st.credit[p][wrrPick] - WEIGHT_W'(1);
          // a spent queue hands its turn on, so the next round starts past it
          if (st.credit[p][wrrPick] == WEIGHT_W'(1)) begin
            next_st.cur[p] = 2'(wrrPick + 2'h1);
          end
        end else begin
          reload[p] = 1'b1;
          next_st.credit[p] = weightEff;
        end
        if (popEn[p]) begin
          next_st.txValid[p] = 1'b1;
          next_st.txData[p] = head[p][popQ[p]];
          next_st.txQueue[p] = popQ[p];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign txValid = st.txValid;
  assign txData = st.txData;
  assign txQueue = st.txQueue;
  assign inReady = qReady;

endmodule : egress_priority_queue_scheduler

//--- tb/tx_mac_model.sv
`timescale 1ns/10ps

module tx_mac_model #(
  parameter int N = 2
) (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic slow,
  output logic [N-1:0] txReady
);
  // holds the port off on command; in slow mode accepts every other cycle
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < N; p++) begin
      txReady[p] <= !stall && !(slow && txReady[p]);
    end
  end
endmodule : tx_mac_model

//--- tb/egress_priority_queue_scheduler_tb.sv
`timescale 1ns/10ps

module egress_priority_queue_scheduler_tb;
  localparam int NP = 2;
  localparam int DW = 16;
  localparam logic [7:0][1:0] MAP_EXP = 16'hFA41;
  localparam logic [7:0][1:0] MAP_ALT = 16'hE4E4;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] strictMask = 4'hF;
  logic mapOverride = 1'b0;
  logic [7:0][1:0] prioMap = '0;
  logic weightOverride = 1'b0;
  logic [3:0][3:0] weights = '0;
  logic [NP-1:0][2:0] defaultPrio = '0;
  logic [NP-1:0] inValid = '0;
  logic [NP-1:0] inReady;
  logic [NP-1:0] inTagPresent = '0;
  logic [NP-1:0][2:0] inPrio = '0;
  logic [NP-1:0][DW-1:0] inData = '0;
  logic [NP-1:0] txValid;
  logic [NP-1:0] txReady;
  logic [NP-1:0][DW-1:0] txData;
  logic [NP-1:0][1:0] txQueue;
  logic stall = 1'b1;
  logic slow = 1'b0;
  int bad_count = 0;
  int num_checks = 0;

  always #2 sys_clk = ~sys_clk;

  egress_priority_queue_scheduler #(.NUM_PORTS(NP), .DATA_W(DW), .DEPTH(8), .WEIGHT_W(4))
    egress_priority_queue_scheduler_inst (
    .sys_clk(sys_clk), .rstn(rstn), .strictMask(strictMask), .mapOverride(mapOverride),
    .prioMap(prioMap), .weightOverride(weightOverride), .weights(weights),
    .defaultPrio(defaultPrio), .inValid(inValid), .inReady(inReady),
    .inTagPresent(inTagPresent), .inPrio(inPrio), .inData(inData), .txValid(txValid),
    .txReady(txReady), .txData(txData), .txQueue(txQueue)
  );

  tx_mac_model #(.N(NP)) tx_mac_model_inst (
    .sys_clk(sys_clk), .stall(stall), .slow(slow), .txReady(txReady)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // one case: reset, queue frames with the port stalled, then drain
  // ----------------------------------------------------------------
  task automatic run_case(input int p, input logic isTagged, input int n, input logic [29:0] tags,
      input int m, input logic [19:0] exp, input logic idleChk);
    int k;
    int got;
    rstn <= 1'b0;
    stall <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < n; i++) begin
      inValid[p] <= 1'b1;
      inTagPresent[p] <= isTagged;
      inPrio[p] <= isTagged ? tags[3*i+:3] : ~tags[3*i+:3];
      defaultPrio[p] <= isTagged ? ~tags[3*i+:3] : tags[3*i+:3];
      inData[p] <= 16'hD000 + DW'(i);
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (inReady[p] !== 1'b1 && k < 50);
      if (k == 50) begin
        check("inReady", 1, 0);
        give_verdict();
      end
    end
    inValid[p] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    stall <= 1'b0;
    got = 0;
    k = 0;
    while (got < m && k < 300) begin
      @(posedge sys_clk);
      k++;
      if (txValid[p] === 1'b1 && txReady[p] === 1'b1) begin
        check("txQueue", DW'(exp[2*got+:2]), DW'(txQueue[p]));
        if (m == 1) begin
          check("txData", 16'hD000, txData[p]);
        end
        got++;
      end
    end
    if (got < m) begin
      check("frameCount", DW'(m), DW'(got));
      give_verdict();
    end
    if (idleChk) begin
      repeat (20) @(posedge sys_clk);
      check("txValidIdle", 0, DW'(txValid[p]));
    end
    check("otherPortIdle", 0, DW'(txValid[1-p]));
  endtask : run_case

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic map_case();
    for (int p = 0; p < NP; p++) begin
      for (int tg = 0; tg < 2; tg++) begin
        for (int t = 0; t < 8; t++) begin
          run_case(p, tg[0], 1, 30'(t), 1, 20'(MAP_EXP[t]), 1'b0);
        end
      end
    end
    mapOverride <= 1'b1;
    prioMap <= MAP_ALT;
    for (int p = 0; p < NP; p++) begin
      for (int t = 0; t < 8; t++) begin
        run_case(p, 1'b1, 1, 30'(t), 1, 20'(MAP_ALT[t]), 1'b0);
      end
    end
    mapOverride <= 1'b0;
  endtask : map_case

  task automatic strict_case();
    strictMask <= 4'hF;
    run_case(1, 1'b1, 4, 30'({3'd3, 3'd5, 3'd7, 3'd1}), 4, 20'({2'd1, 2'd2, 2'd3, 2'd0}), 1'b1);
    strictMask <= 4'hC;
    run_case(0, 1'b1, 3, 30'({3'd7, 3'd3, 3'd1}), 3, 20'({2'd1, 2'd3, 2'd0}), 1'b1);
  endtask : strict_case

  task automatic wrr_default_case();
    strictMask <= 4'h0;
    weightOverride <= 1'b0;
    slow <= 1'b1;
    run_case(0, 1'b1, 9, 30'({3'd5, 3'd5, 3'd5, 3'd5, 3'd5, 3'd3, 3'd3, 3'd3, 3'd1}), 9,
      20'({2'd2, 2'd1, 2'd2, 2'd2, 2'd2, 2'd2, 2'd1, 2'd1, 2'd0}), 1'b1);
    slow <= 1'b0;
  endtask : wrr_default_case

  task automatic wrr_equal_case();
    strictMask <= 4'h0;
    weightOverride <= 1'b1;
    weights <= 16'h1111;
    run_case(1, 1'b1, 5, 30'({3'd5, 3'd5, 3'd3, 3'd3, 3'd1}), 5,
      20'({2'd2, 2'd1, 2'd2, 2'd1, 2'd0}), 1'b1);
  endtask : wrr_equal_case

  task automatic wrr_zero_case();
    strictMask <= 4'h0;
    weightOverride <= 1'b1;
    weights <= 16'h0321;
    run_case(0, 1'b1, 4, 30'({3'd3, 3'd7, 3'd1, 3'd1}), 3, 20'({2'd0, 2'd1, 2'd0}), 1'b1);
    weightOverride <= 1'b0;
  endtask : wrr_zero_case

  initial begin
    repeat (5) @(posedge sys_clk);
    map_case();
    strict_case();
    wrr_default_case();
    wrr_equal_case();
    wrr_zero_case();
    give_verdict();
  end
endmodule : egress_priority_queue_scheduler_tb
